//--- src/mcio_consts.vh
// Purpose: constants for the microcontroller i/o port block
// Assumes: apb byte addresses, one aligned word per register
// Notes:   offsets are local to the block
`ifndef MCIO_CONSTS_VH
`define MCIO_CONSTS_VH
// ****************************************
// register map
// ****************************************
`define MCIO_A_WAKE_CFG    12'h000
`define MCIO_A_WAKE_DATA   12'h004
`define MCIO_A_WAKE_PIN    12'h008
`define MCIO_A_SPEC_CFG    12'h00C
`define MCIO_A_SPEC_DATA   12'h010
`define MCIO_A_SPEC_PIN    12'h014
`define MCIO_A_NARROW_CFG  12'h018
`define MCIO_A_NARROW_DATA 12'h01C
`define MCIO_A_NARROW_PIN  12'h020
`define MCIO_A_STATUS      12'h024
// ****************************************
// field positions and values
// ****************************************
`define MCIO_RST8          8'h00
`define MCIO_RST4          4'h0
`define MCIO_ZERO24        24'h000000
`define MCIO_ZERO28        28'h0000000
`define MCIO_ZERO30        30'h00000000
`define MCIO_B_IRQ         0
`define MCIO_B_SUPV        1
`define MCIO_B_TCAP        2
`define MCIO_B_TIO         3
`define MCIO_B_SDO         4
`define MCIO_B_SCK         5
`define MCIO_B_IDLE        6
`define MCIO_B_HALT        7
`define MCIO_NARROW_W      4
`endif

//--- src/mcio_pin.v
// Purpose: one i/o pin cell: mode decode and two-stage input sampling
// Assumes: pad level arrives asynchronously
// Notes:   mode pair is configuration bit and data bit
`timescale 1ns/1ns
`default_nettype none
module mcio_pin (
  // clock and reset
  input  wire clk_i,
  input  wire rstn_i,
  // settings
  input  wire cfg_i,
  input  wire dat_i,
  // pad
  input  wire pad_i,
  output wire pad_o,
  output wire pad_oe_o,
  output wire pull_o,
  output wire level_o
);
  reg meta;
  reg sync;
  // ****************************************
  // mode decode
  // ****************************************
  assign pad_oe_o = cfg_i;
  assign pad_o    = dat_i;
  assign pull_o   = ~cfg_i & dat_i;
  assign level_o  = sync;
  // ****************************************
  // input synchroniser
  // ****************************************
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= pad_i;
      sync <= meta;
    end
  end
endmodule // mcio_pin
`default_nettype wire

//--- src/mcio_top.v
// Purpose: memory-mapped general-purpose i/o: wake port, special port, narrow port
// Assumes: apb slave, 32-bit data, zero-wait answers
// Notes:   option straps are parameters; pins are input, output, enable and pull-up groups
// Notes on behaviour
// - cfg/data pair: 00 hi-z in, 01 pulled-up in, 10 drive low, 11 drive high
// - two 8-bit ports and one narrow port, every bit set independently
// - each port has configuration, output data and pin level locations
// - all eight wake port pins feed the wakeup logic
// - special bit 6 is always a hi-z input
// - with supervisor option, bit 1 drives supervisor output with weak pull-up
// - without supervisor option, bit 1 is an ordinary i/o pin
// - with crystal option, bit 7 is the oscillator clock output
// - with rc option, bit 7 is hi-z input; rising edge wakes from halt
// - special data bits 6 and 7 read back as zero
// - writing one to special data bit 7 enters halt
// - writing one to special data bit 6 enters idle
// - special configuration bit 6 selects alternate serial clock phase
// - special configuration bit 7 enables restart delay leaving halt on rc
// - special pins carry serial, timer and external interrupt functions
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "mcio_consts.vh"
module mcio_top #(
  parameter SUPERVISOR_FITTED = 1'b1,
  parameter CRYSTAL_OSC       = 1'b0
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rstn_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // wake port pins
  input  wire [7:0]  wake_pad_i,
  output wire [7:0]  wake_pad_o,
  output wire [7:0]  wake_pad_oe_o,
  output wire [7:0]  wake_pull_o,
  output wire [7:0]  wakeup_level_o,
  // special port pins
  input  wire [7:0]  spec_pad_i,
  output wire [7:0]  spec_pad_o,
  output wire [7:0]  spec_pad_oe_o,
  output wire [7:0]  spec_pull_o,
  // narrow port pins
  input  wire [3:0]  narrow_pad_i,
  output wire [3:0]  narrow_pad_o,
  output wire [3:0]  narrow_pad_oe_o,
  output wire [3:0]  narrow_pull_o,
  // on-chip functions
  input  wire        oscillator_clock_out_i,
  input  wire        supervisor_output_i,
  input  wire        serial_data_out_i,
  input  wire        serial_data_out_en_i,
  input  wire        timer_io_out_i,
  input  wire        timer_io_out_en_i,
  input  wire        halt_exit_i,
  input  wire        idle_exit_i,
  output wire        serial_data_in_o,
  output wire        serial_shift_clock_o,
  output wire        timer_io_pin_o,
  output wire        timer_capture_input_o,
  output wire        external_irq_input_o,
  output wire        alt_shift_clock_phase_o,
  output wire        halt_restart_delay_enable_o,
  output wire        halt_req_o,
  output wire        idle_req_o,
  output wire        halt_wake_o
);
  // ****************************************
  // registers
  // ****************************************
  reg  [7:0] wake_cfg;
  reg  [7:0] wake_data;
  reg  [7:0] spec_cfg;
  reg  [7:0] spec_data;
  reg  [3:0] narrow_cfg;
  reg  [3:0] narrow_data;
  reg        halt_req;
  reg        idle_req;
  reg        bit7_prev;
  reg        halt_wake;
  reg [31:0] prdata;
  reg [31:0] next_prdata;
  wire [7:0] wake_lvl;
  wire [7:0] spec_lvl;
  wire [3:0] narrow_lvl;
  wire [7:0] spec_cfg_eff;
  wire [7:0] spec_dat_eff;
  wire [7:0] spec_oe_raw;
  wire [7:0] spec_o_raw;
  wire [7:0] spec_pull_raw;
  wire       wr;
  wire       rd;
  wire       hit;
  wire [7:0] spec_data_rd;
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & ~penable_i & ~pwrite_i;
  // ****************************************
  // pin cells
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_wake
      mcio_pin u_pin (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .cfg_i    (wake_cfg[g]),
        .dat_i    (wake_data[g]),
        .pad_i    (wake_pad_i[g]),
        .pad_o    (wake_pad_o[g]),
        .pad_oe_o (wake_pad_oe_o[g]),
        .pull_o   (wake_pull_o[g]),
        .level_o  (wake_lvl[g])
      );
      mcio_pin u_spec (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .cfg_i    (spec_cfg_eff[g]),
        .dat_i    (spec_dat_eff[g]),
        .pad_i    (spec_pad_i[g]),
        .pad_o    (spec_o_raw[g]),
        .pad_oe_o (spec_oe_raw[g]),
        .pull_o   (spec_pull_raw[g]),
        .level_o  (spec_lvl[g])
      );
    end
    for (g = 0; g < `MCIO_NARROW_W; g = g + 1) begin : g_narrow
      mcio_pin u_pin (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .cfg_i    (narrow_cfg[g]),
        .dat_i    (narrow_data[g]),
        .pad_i    (narrow_pad_i[g]),
        .pad_o    (narrow_pad_o[g]),
        .pad_oe_o (narrow_pad_oe_o[g]),
        .pull_o   (narrow_pull_o[g]),
        .level_o  (narrow_lvl[g])
      );
    end
  endgenerate
  assign wakeup_level_o = wake_lvl;
  // ****************************************
  // special port overrides
  // ****************************************
  // bits 6 and 7 are forced to hi-z input inside the cell; owners drive them here
  assign spec_cfg_eff = {2'b00, spec_cfg[5:0]};
  assign spec_dat_eff = {2'b00, spec_data[5:0]};
  // serial data out and timer i/o take over their pins when enabled
  assign spec_pad_oe_o[`MCIO_B_IRQ]  = spec_oe_raw[`MCIO_B_IRQ];
  assign spec_pad_o[`MCIO_B_IRQ]     = spec_o_raw[`MCIO_B_IRQ];
  assign spec_pull_o[`MCIO_B_IRQ]    = spec_pull_raw[`MCIO_B_IRQ];
  // supervisor: weak pull-up high, driven low when output low
  assign spec_pad_oe_o[`MCIO_B_SUPV] = SUPERVISOR_FITTED ?
    ~supervisor_output_i : spec_oe_raw[`MCIO_B_SUPV];
  assign spec_pad_o[`MCIO_B_SUPV]    = SUPERVISOR_FITTED ?
    1'b0 : spec_o_raw[`MCIO_B_SUPV];
  assign spec_pull_o[`MCIO_B_SUPV]   = SUPERVISOR_FITTED ?
    1'b1 : spec_pull_raw[`MCIO_B_SUPV];
  assign spec_pad_oe_o[`MCIO_B_TCAP] = spec_oe_raw[`MCIO_B_TCAP];
  assign spec_pad_o[`MCIO_B_TCAP]    = spec_o_raw[`MCIO_B_TCAP];
  assign spec_pull_o[`MCIO_B_TCAP]   = spec_pull_raw[`MCIO_B_TCAP];
  assign spec_pad_oe_o[`MCIO_B_TIO]  = spec_oe_raw[`MCIO_B_TIO] | timer_io_out_en_i;
  assign spec_pad_o[`MCIO_B_TIO]     = timer_io_out_en_i ?
    timer_io_out_i : spec_o_raw[`MCIO_B_TIO];
  assign spec_pull_o[`MCIO_B_TIO]    = spec_pull_raw[`MCIO_B_TIO];
  assign spec_pad_oe_o[`MCIO_B_SDO]  = spec_oe_raw[`MCIO_B_SDO] | serial_data_out_en_i;
  assign spec_pad_o[`MCIO_B_SDO]     = serial_data_out_en_i ?
    serial_data_out_i : spec_o_raw[`MCIO_B_SDO];
  assign spec_pull_o[`MCIO_B_SDO]    = spec_pull_raw[`MCIO_B_SDO];
  assign spec_pad_oe_o[`MCIO_B_SCK]  = spec_oe_raw[`MCIO_B_SCK];
  assign spec_pad_o[`MCIO_B_SCK]     = spec_o_raw[`MCIO_B_SCK];
  assign spec_pull_o[`MCIO_B_SCK]    = spec_pull_raw[`MCIO_B_SCK];
  assign spec_pad_oe_o[`MCIO_B_IDLE] = 1'b0;
  assign spec_pad_o[`MCIO_B_IDLE]    = 1'b0;
  assign spec_pull_o[`MCIO_B_IDLE]   = 1'b0;
  assign spec_pad_oe_o[`MCIO_B_HALT] = CRYSTAL_OSC;
  assign spec_pad_o[`MCIO_B_HALT]    = CRYSTAL_OSC ? oscillator_clock_out_i : 1'b0;
  assign spec_pull_o[`MCIO_B_HALT]   = 1'b0;
  // ****************************************
  // alternate functions
  // ****************************************
  assign external_irq_input_o   = spec_lvl[`MCIO_B_IRQ];
  assign timer_capture_input_o  = spec_lvl[`MCIO_B_TCAP];
  assign timer_io_pin_o         = spec_lvl[`MCIO_B_TIO];
  assign serial_shift_clock_o   = spec_lvl[`MCIO_B_SCK];
  assign serial_data_in_o       = spec_lvl[`MCIO_B_IDLE];
  assign alt_shift_clock_phase_o     = spec_cfg[`MCIO_B_IDLE];
  assign halt_restart_delay_enable_o = spec_cfg[`MCIO_B_HALT] & ~CRYSTAL_OSC;
  assign halt_req_o  = halt_req;
  assign idle_req_o  = idle_req;
  assign halt_wake_o = halt_wake;
  // ****************************************
  // register writes and mode requests
  // ****************************************
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_cfg    <= `MCIO_RST8;
      wake_data   <= `MCIO_RST8;
      spec_cfg    <= `MCIO_RST8;
      spec_data   <= `MCIO_RST8;
      narrow_cfg  <= `MCIO_RST4;
      narrow_data <= `MCIO_RST4;
      halt_req    <= 1'b0;
      idle_req    <= 1'b0;
      bit7_prev   <= 1'b0;
      halt_wake   <= 1'b0;
    end else begin
      bit7_prev <= spec_lvl[`MCIO_B_HALT];
      halt_wake <= ~CRYSTAL_OSC & halt_req &
                   spec_lvl[`MCIO_B_HALT] & ~bit7_prev;
      if (halt_exit_i | halt_wake)
        halt_req <= 1'b0;
      if (idle_exit_i)
        idle_req <= 1'b0;
      if (wr) begin
        case (paddr_i)
          `MCIO_A_WAKE_CFG:    wake_cfg    <= pwdata_i[7:0];
          `MCIO_A_WAKE_DATA:   wake_data   <= pwdata_i[7:0];
          `MCIO_A_SPEC_CFG:    spec_cfg    <= pwdata_i[7:0];
          `MCIO_A_SPEC_DATA: begin
            spec_data <= pwdata_i[7:0];
            if (pwdata_i[`MCIO_B_HALT])
              halt_req <= 1'b1;
            if (pwdata_i[`MCIO_B_IDLE])
              idle_req <= 1'b1;
          end
          `MCIO_A_NARROW_CFG:  narrow_cfg  <= pwdata_i[3:0];
          `MCIO_A_NARROW_DATA: narrow_data <= pwdata_i[3:0];
          default: ;
        endcase
      end
    end
  end
  // ****************************************
  // register reads
  // ****************************************
  assign spec_data_rd = {2'b00, spec_data[5:0]};
  assign hit = (paddr_i == `MCIO_A_WAKE_CFG)   | (paddr_i == `MCIO_A_WAKE_DATA) |
               (paddr_i == `MCIO_A_WAKE_PIN)   | (paddr_i == `MCIO_A_SPEC_CFG)  |
               (paddr_i == `MCIO_A_SPEC_DATA)  | (paddr_i == `MCIO_A_SPEC_PIN)  |
               (paddr_i == `MCIO_A_NARROW_CFG) | (paddr_i == `MCIO_A_NARROW_DATA) |
               (paddr_i == `MCIO_A_NARROW_PIN) | (paddr_i == `MCIO_A_STATUS);
  always @* begin
    next_prdata = prdata;
    if (rd) begin
      case (paddr_i)
        `MCIO_A_WAKE_CFG:    next_prdata = {`MCIO_ZERO24, wake_cfg};
        `MCIO_A_WAKE_DATA:   next_prdata = {`MCIO_ZERO24, wake_data};
        `MCIO_A_WAKE_PIN:    next_prdata = {`MCIO_ZERO24, wake_lvl};
        `MCIO_A_SPEC_CFG:    next_prdata = {`MCIO_ZERO24, spec_cfg};
        `MCIO_A_SPEC_DATA:   next_prdata = {`MCIO_ZERO24, spec_data_rd};
        `MCIO_A_SPEC_PIN:    next_prdata = {`MCIO_ZERO24, spec_lvl};
        `MCIO_A_NARROW_CFG:  next_prdata = {`MCIO_ZERO28, narrow_cfg};
        `MCIO_A_NARROW_DATA: next_prdata = {`MCIO_ZERO28, narrow_data};
        `MCIO_A_NARROW_PIN:  next_prdata = {`MCIO_ZERO28, narrow_lvl};
        `MCIO_A_STATUS:      next_prdata = {`MCIO_ZERO30, idle_req, halt_req};
        default:             next_prdata = {`MCIO_ZERO24, `MCIO_RST8};
      endcase
    end
  end
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      prdata <= {`MCIO_ZERO24, `MCIO_RST8};
    else
      prdata <= next_prdata;
  end
  assign prdata_o  = prdata;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;
endmodule // mcio_top
`default_nettype wire

//--- dv/mcio_checker_assertions.sv
// Purpose: concurrent checks on the i/o port block ports
// Assumes: one clock, async active-low reset
// Notes:   bound into mcio_top
`timescale 1ns/1ns
`default_nettype none
`include "mcio_consts.vh"
module mcio_checker #(
  parameter SUPERVISOR_FITTED = 1'b1,
  parameter CRYSTAL_OSC       = 1'b0
) (
  // clock, reset, apb
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  // pins and functions
  input wire logic [7:0]  spec_pad_oe_o,
  input wire logic [7:0]  spec_pull_o,
  input wire logic [3:0]  narrow_pad_oe_o,
  input wire logic        alt_shift_clock_phase_o,
  input wire logic        halt_restart_delay_enable_o,
  input wire logic        halt_req_o,
  input wire logic        idle_req_o,
  input wire logic        halt_wake_o
);
  // ****************************************
  // port checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic wr;
  logic rd;
  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && penable_i && !pwrite_i;
  chk_ready_high: assert property (pready_o)
    else $error("ready low");
  chk_narrow_drive: assert property (wr && paddr_i == `MCIO_A_NARROW_CFG
    |=> narrow_pad_oe_o == $past(pwdata_i[3:0])) else $error("narrow enables wrong");
  chk_bit6_hiz: assert property (spec_pad_oe_o[6] == 1'b0)
    else $error("bit6 driven");
  chk_supv_pull: assert property (SUPERVISOR_FITTED |-> spec_pull_o[1])
    else $error("bit1 not pulled");
  chk_halt_set: assert property (wr && paddr_i == `MCIO_A_SPEC_DATA && pwdata_i[7]
    |=> halt_req_o) else $error("halt not requested");
  chk_idle_set: assert property (wr && paddr_i == `MCIO_A_SPEC_DATA && pwdata_i[6]
    |=> idle_req_o) else $error("idle not requested");
  chk_alt_phase: assert property (wr && paddr_i == `MCIO_A_SPEC_CFG
    |=> alt_shift_clock_phase_o == $past(pwdata_i[6])) else $error("phase wrong");
  chk_delay_en: assert property (wr && paddr_i == `MCIO_A_SPEC_CFG
    |=> halt_restart_delay_enable_o == ($past(pwdata_i[7]) && !CRYSTAL_OSC))
    else $error("delay enable wrong");
  chk_data_top_zero: assert property (rd && paddr_i == `MCIO_A_SPEC_DATA
    |-> prdata_o[7:6] == 2'b00) else $error("data bits 7:6 not zero");
  chk_wake_pulse: assert property (halt_wake_o |-> $past(halt_req_o) ##1 !halt_wake_o)
    else $error("wake pulse wrong");
  chk_wake_clear: assert property (halt_wake_o && !(wr && paddr_i == `MCIO_A_SPEC_DATA)
    |=> !halt_req_o) else $error("halt not cleared by wake");
endmodule // mcio_checker
bind mcio_top mcio_checker #(.SUPERVISOR_FITTED(SUPERVISOR_FITTED), .CRYSTAL_OSC(CRYSTAL_OSC))
  mcio_checker_i (.*);
`default_nettype wire

//--- dv/mcio_pad_model.sv
// Purpose: external circuits on the port pins
// Assumes: per-pin far-side drive with its own enable
// Notes:   a floating line reads high when pulled, else the inverse of the block's data
`timescale 1ns/1ns
`default_nettype none
module mcio_pad_model #(
  parameter W = 20
) (
  // block side
  input  wire logic [W-1:0] drive_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] pull_i,
  // far side
  input  wire logic [W-1:0] ext_i,
  input  wire logic [W-1:0] ext_oe_i,
  output wire logic [W-1:0] level_o
);
  // ****************************************
  // wire resolution
  // ****************************************
  assign level_o = (oe_i & drive_i) | (~oe_i & ext_oe_i & ext_i)
                 | (~oe_i & ~ext_oe_i & (pull_i | ~drive_i));
endmodule // mcio_pad_model
`default_nettype wire

//--- dv/tb_top.sv
// Purpose: self-checking bench for the i/o port block
// Assumes: zero-wait apb slave, default options
// Notes:   expected values worked from the mode table
`timescale 1ns/1ns
`default_nettype none
`include "mcio_consts.vh"
module tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [7:0] wk_o, wk_oe, wk_pu, wake_lvl, sp_o, sp_oe, sp_pu;
  logic [3:0] nr_o, nr_oe, nr_pu;
  logic [19:0] ext, ext_oe, lvl;
  logic supv, tio, tio_en, idle_x, sdi, sck, tpin, tcap, irq, alt, dly, halt, idle, wake, halt_x;
  int fails, checks_done, cycles;
  mcio_top mcio_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .wake_pad_i(lvl[7:0]), .wake_pad_o(wk_o), .wake_pad_oe_o(wk_oe), .wake_pull_o(wk_pu),
    .wakeup_level_o(wake_lvl), .spec_pad_i(lvl[15:8]), .spec_pad_o(sp_o),
    .spec_pad_oe_o(sp_oe), .spec_pull_o(sp_pu), .narrow_pad_i(lvl[19:16]),
    .narrow_pad_o(nr_o), .narrow_pad_oe_o(nr_oe), .narrow_pull_o(nr_pu),
    .oscillator_clock_out_i(1'b0), .supervisor_output_i(supv), .serial_data_out_i(tio),
    .serial_data_out_en_i(tio_en), .timer_io_out_i(tio), .timer_io_out_en_i(tio_en),
    .halt_exit_i(halt_x), .idle_exit_i(idle_x), .serial_data_in_o(sdi),
    .serial_shift_clock_o(sck), .timer_io_pin_o(tpin), .timer_capture_input_o(tcap),
    .external_irq_input_o(irq), .alt_shift_clock_phase_o(alt),
    .halt_restart_delay_enable_o(dly), .halt_req_o(halt), .idle_req_o(idle),
    .halt_wake_o(wake));
  mcio_pad_model mcio_pad_model_i (.drive_i({nr_o, sp_o, wk_o}),
    .oe_i({nr_oe, sp_oe, wk_oe}), .pull_i({nr_pu, sp_pu, wk_pu}), .ext_i(ext),
    .ext_oe_i(ext_oe), .level_o(lvl));
  // ****************************************
  // tasks
  // ****************************************
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t pin got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    cmp_pin({7'h00, e}, {7'h00, err});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    cmp_reg(q, exp);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // clock, timeout, tests
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      wrap_up;
    end
  end
  initial begin
    fails = 0; checks_done = 0; cycles = 0; rstn_i = 1'b0;
    psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0; paddr_i = 12'h000; pwdata_i = 32'h0;
    supv = 1'b1; tio = 1'b0; tio_en = 1'b0; idle_x = 1'b0; halt_x = 1'b0;
    ext = {4'h0, 8'h45, 8'h3C}; ext_oe = {4'h0, 8'hFD, 8'hFF};
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(`MCIO_A_WAKE_CFG, 32'h0);
    rd(`MCIO_A_NARROW_DATA, 32'h0);
    wr(`MCIO_A_NARROW_CFG, 32'h0C, 1'b0);
    wr(`MCIO_A_NARROW_DATA, 32'h0A, 1'b0);
    repeat (3) @(posedge clk_i);
    cmp_pin({nr_oe, nr_pu}, 8'hC2);
    cmp_pin({4'h0, nr_o}, 8'h0A);
    rd(`MCIO_A_NARROW_PIN, 32'h0B);
    wr(`MCIO_A_WAKE_CFG, 32'hA5, 1'b0);
    wr(`MCIO_A_WAKE_DATA, 32'hFF, 1'b0);
    repeat (3) @(posedge clk_i);
    cmp_pin(wk_oe, 8'hA5);
    cmp_pin(wk_pu, 8'h5A);
    cmp_pin(wk_o, 8'hFF);
    cmp_pin(wake_lvl, 8'hBD);
    rd(`MCIO_A_WAKE_PIN, 32'hBD);
    cmp_pin({3'h0, sdi, sck, tpin, tcap, irq}, 8'h13);
    wr(`MCIO_A_SPEC_CFG, 32'hC2, 1'b0);
    wr(`MCIO_A_SPEC_DATA, 32'hC0, 1'b0);
    @(posedge clk_i);
    cmp_pin({alt, dly, sp_oe[7:6], sp_oe[1], sp_pu[1]}, 8'h31);
    rd(`MCIO_A_SPEC_DATA, 32'h0);
    rd(`MCIO_A_STATUS, 32'h3);
    idle_x <= 1'b1;
    @(posedge clk_i);
    idle_x <= 1'b0;
    rd(`MCIO_A_STATUS, 32'h1);
    ext[15] <= 1'b1;
    repeat (10) if (wake !== 1'b1) @(negedge clk_i);
    cmp_pin({7'h00, wake}, 8'h01);
    repeat (2) @(posedge clk_i);
    cmp_pin({7'h00, halt}, 8'h00);
    supv <= 1'b0; tio <= 1'b1; tio_en <= 1'b1;
    repeat (2) @(posedge clk_i);
    cmp_pin({4'h0, sp_oe[1], sp_o[1], sp_oe[3], sp_o[3]}, 8'h0B);
    cmp_pin({6'h00, sp_oe[4], sp_o[4]}, 8'h03);
    wr(12'h030, 32'hFF, 1'b1);
    rd(12'h030, 32'h0);
    wr(`MCIO_A_SPEC_DATA, 32'h80, 1'b0);
    rd(`MCIO_A_STATUS, 32'h1);
    halt_x <= 1'b1;
    @(posedge clk_i);
    halt_x <= 1'b0;
    rd(`MCIO_A_STATUS, 32'h0);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(`MCIO_A_SPEC_CFG, 32'h0);
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
